//--- src/port_pins_cfg.svh
// Constants for the six-port pin block: offsets, fields, pin positions
`ifndef PORT_PINS_CFG_SVH
`define PORT_PINS_CFG_SVH

// ==========================================================
// Register offsets
`define ADDR_DATA 8'h00
`define ADDR_DIR 8'h08
`define ADDR_PU 8'h10
`define ADDR_ALT 8'h18
`define ADDR_EDGE 8'h19
`define ADDR_STAT 8'h1a
`define ADDR_MASK 8'h1b
`define NUM_PORTS 6
`define LAST_PORT 3'h5

// ==========================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_ALT 5'h00
`define RST_EDGE 6'h00
`define RST_STAT 4'h0

// ==========================================================
// Port widths as masks
`define MASK_8 8'hff
`define MASK_3 8'h07
`define MASK_4 8'h0f

// ==========================================================
// Flat pin positions
`define PIN_C0 16
`define PIN_C1 17
`define PIN_C2 18
`define PIN_D0 19
`define PIN_E0 22
`define PIN_F0 30
`define PIN_F1 31
`define NUM_PINS 34

// ==========================================================
// Alternate control fields
`define ALT_SER_EN 0
`define ALT_ASYNC 1
`define ALT_SCK_MST 2
`define ALT_TMR8_OUT 3
`define ALT_TMR16_OUT 4

// ==========================================================
// Status fields
`define ST_KEY 3

`endif

//--- src/port_pkg.sv
// Types shared by the six-port pin block
package port_pkg;

	typedef enum logic [1:0]
	{
		EDGE_OFF = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} edge_e;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed
	{
		logic [33:0] o;
		logic [33:0] oe;
		logic [33:0] pu;
	} pin_drive_s;

	typedef struct packed
	{
		logic ser_clk;
		logic ser_data;
		logic tmr8;
		logic tmr16;
	} periph_drive_s;

	typedef struct packed
	{
		logic sync_serial_clock;
		logic async_serial_clock_in;
		logic sync_serial_in;
		logic timer8_count_in;
		logic capture_trigger_in;
		logic [7:0] key_return_inputs;
		logic [2:0] ext_irq;
	} alt_in_s;

endpackage : port_pkg

//--- src/port_pins_with_alternates.sv
// Six general-purpose ports with pull-ups, alternates and pin interrupts
`timescale 1ns/1ps
`include "port_pins_cfg.svh"

// Functional notes
// - Direction set per bit by software
// - Pull-up only acts on input pins
// - Ports A, B, E are eight bits
// - Ports C and D are three bits
// - Port F is four bits
// - External interrupts: rising, falling or both
// - C bit0 is serial clock, both modes
// - Async mode: clock pin input only
// - C bit2 is serial data input
// - C bit1 is serial data output
// - Alternate output pins reset as inputs
// - F bit0 feeds timer8 count input
// - F bit0 alternatively drives timer8 output
// - F bit1 drives timer16 output
// - D bit2 is irq c and capture
// - Port E pins are key-return inputs
module port_pins_with_alternates
	import port_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire reg_req_s bus,
	output logic [7:0] rd_data,
	input wire logic [33:0] pin_in,
	output pin_drive_s pins,
	input wire periph_drive_s periph,
	output alt_in_s to_periph,
	output logic irq
);

	// ======================================================
	// Decoding helpers
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] base);
		hit = (a[7:3] == base[7:3]) && (a[2:0] <= `LAST_PORT);
	endfunction : hit

	function automatic logic [7:0] port_mask(input logic [2:0] i);
		case (i)
			3'h2, 3'h3: port_mask = `MASK_3;
			3'h5: port_mask = `MASK_4;
			default: port_mask = `MASK_8;
		endcase
	endfunction : port_mask

	function automatic logic [33:0] pack_ports(
		input logic [7:0] p [`NUM_PORTS]);
		pack_ports = {p[5][3:0], p[4], p[3][2:0], p[2][2:0],
			p[1], p[0]};
	endfunction : pack_ports

	function automatic logic [7:0] port_slice(input logic [33:0] v,
		input logic [2:0] i);
		case (i)
			3'h0: port_slice = v[7:0];
			3'h1: port_slice = v[15:8];
			3'h2: port_slice = {5'h00, v[18:16]};
			3'h3: port_slice = {5'h00, v[21:19]};
			3'h4: port_slice = v[29:22];
			3'h5: port_slice = {4'h0, v[33:30]};
			default: port_slice = 8'h00;
		endcase
	endfunction : port_slice

	// ======================================================
	// Pin synchronisers and edge history
	logic [33:0] sync1_r;
	logic [33:0] sync2_r;
	logic [33:0] hist_r;

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			hist_r <= '0;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			hist_r <= sync2_r;
		end
	end

	// ======================================================
	// Register file
	logic [7:0] latch_r [`NUM_PORTS];
	logic [7:0] latch_nxt [`NUM_PORTS];
	logic [7:0] dir_r [`NUM_PORTS];
	logic [7:0] dir_nxt [`NUM_PORTS];
	logic [7:0] pu_r [`NUM_PORTS];
	logic [7:0] pu_nxt [`NUM_PORTS];
	logic [4:0] alt_r;
	logic [4:0] alt_nxt;
	logic [5:0] edge_r;
	logic [5:0] edge_nxt;
	logic [3:0] status_r;
	logic [3:0] status_nxt;
	logic [3:0] mask_r;
	logic [3:0] mask_nxt;
	logic [7:0] rd_nxt;
	logic irq_nxt;
	logic [33:0] latch_v;
	logic [33:0] dir_v;
	logic [33:0] pu_v;
	logic [33:0] read_v;
	logic [3:0] events;
	logic [2:0] pidx;

	assign latch_v = pack_ports(latch_r);
	assign dir_v = pack_ports(dir_r);
	assign pu_v = pack_ports(pu_r);
	assign pidx = bus.addr[2:0];
	// Outputs reflect the latch; inputs reflect the synchronised pin
	assign read_v = (dir_v & latch_v) | (~dir_v & sync2_r);

	// One edge detector per external interrupt line
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_ext
			logic rise;
			logic fall;
			edge_e sel;
			assign rise = sync2_r[`PIN_D0 + g] & ~hist_r[`PIN_D0 + g];
			assign fall = ~sync2_r[`PIN_D0 + g] & hist_r[`PIN_D0 + g];
			assign sel = edge_e'(edge_r[2 * g +: 2]);
			assign events[g] = (sel[0] & rise) | (sel[1] & fall);
		end
	endgenerate

	// Any falling key line among the input pins of port E
	assign events[`ST_KEY] = |(hist_r[29:22] & ~sync2_r[29:22]
		& ~dir_v[29:22]);

	always_comb
	begin
		latch_nxt = latch_r;
		dir_nxt = dir_r;
		pu_nxt = pu_r;
		alt_nxt = alt_r;
		edge_nxt = edge_r;
		mask_nxt = mask_r;
		rd_nxt = 8'h00;
		if (bus.wr)
		begin
			if (hit(bus.addr, `ADDR_DATA))
				latch_nxt[pidx] = bus.wdata & port_mask(pidx);
			else if (hit(bus.addr, `ADDR_DIR))
				dir_nxt[pidx] = bus.wdata & port_mask(pidx);
			else if (hit(bus.addr, `ADDR_PU))
				pu_nxt[pidx] = bus.wdata & port_mask(pidx);
			else if (bus.addr == `ADDR_ALT)
				alt_nxt = bus.wdata[4:0];
			else if (bus.addr == `ADDR_EDGE)
				edge_nxt = bus.wdata[5:0];
			else if (bus.addr == `ADDR_MASK)
				mask_nxt = bus.wdata[3:0];
		end
		// A new event beats a write-one clear in the same cycle
		status_nxt = status_r;
		if (bus.wr && bus.addr == `ADDR_STAT)
			status_nxt = status_r & ~bus.wdata[3:0];
		status_nxt = status_nxt | events;
		if (bus.rd)
		begin
			if (hit(bus.addr, `ADDR_DATA))
				rd_nxt = port_slice(read_v, pidx);
			else if (hit(bus.addr, `ADDR_DIR))
				rd_nxt = dir_r[pidx];
			else if (hit(bus.addr, `ADDR_PU))
				rd_nxt = pu_r[pidx];
			else if (bus.addr == `ADDR_ALT)
				rd_nxt = {3'h0, alt_r};
			else if (bus.addr == `ADDR_EDGE)
				rd_nxt = {2'h0, edge_r};
			else if (bus.addr == `ADDR_STAT)
				rd_nxt = {4'h0, status_r};
			else if (bus.addr == `ADDR_MASK)
				rd_nxt = {4'h0, mask_r};
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `NUM_PORTS; i++)
			begin
				latch_r[i] <= `RST_BYTE;
				dir_r[i] <= `RST_BYTE;
				pu_r[i] <= `RST_BYTE;
			end
			alt_r <= `RST_ALT;
			edge_r <= `RST_EDGE;
			status_r <= `RST_STAT;
			mask_r <= `RST_STAT;
			rd_data <= 8'h00;
			irq <= 1'b0;
		end
		else
		begin
			latch_r <= latch_nxt;
			dir_r <= dir_nxt;
			pu_r <= pu_nxt;
			alt_r <= alt_nxt;
			edge_r <= edge_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			rd_data <= rd_nxt;
			irq <= irq_nxt;
		end
	end

	// ======================================================
	// Pin drive with alternate overrides
	pin_drive_s pins_nxt;
	logic ser_en;
	logic clk_in_only;

	assign ser_en = alt_r[`ALT_SER_EN];
	// Async or slave clocking keeps the clock pin undriven
	assign clk_in_only = alt_r[`ALT_ASYNC] | ~alt_r[`ALT_SCK_MST];

	always_comb
	begin
		pins_nxt.o = latch_v;
		pins_nxt.oe = dir_v;
		// Alternates only reach a pin whose direction is output,
		// so after reset every such pin floats as an input
		if (ser_en && !clk_in_only)
			pins_nxt.o[`PIN_C0] = periph.ser_clk;
		if (ser_en && clk_in_only)
			pins_nxt.oe[`PIN_C0] = 1'b0;
		if (ser_en)
			pins_nxt.o[`PIN_C1] = periph.ser_data;
		if (alt_r[`ALT_TMR8_OUT])
			pins_nxt.o[`PIN_F0] = periph.tmr8;
		if (alt_r[`ALT_TMR16_OUT])
			pins_nxt.o[`PIN_F1] = periph.tmr16;
		pins_nxt.pu = pu_v & ~pins_nxt.oe;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			pins <= '0;
		else
			pins <= pins_nxt;
	end

	// ======================================================
	// Inputs handed to the peripherals, all from synchronisers
	assign to_periph.sync_serial_clock = sync2_r[`PIN_C0];
	assign to_periph.async_serial_clock_in = sync2_r[`PIN_C0];
	assign to_periph.sync_serial_in = sync2_r[`PIN_C2];
	assign to_periph.timer8_count_in = sync2_r[`PIN_F0];
	assign to_periph.capture_trigger_in = sync2_r[`PIN_D0 + 2];
	assign to_periph.key_return_inputs = sync2_r[29:22];
	assign to_periph.ext_irq = sync2_r[21:19];

	// ======================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_reset_inputs: assert property (
		$rose(rst_n) |-> (pins.oe == '0 && pins.pu == '0))
		else $error("pins not inputs after reset");
	a_pullup_input: assert property (
		(pins.pu & pins.oe) == '0)
		else $error("pull-up on an output pin");
	a_dir_write: assert property (
		bus.wr && bus.addr == `ADDR_DIR |=>
		##1 pins.oe[7:0] == $past(bus.wdata, 2))
		else $error("direction write not on pins");
	a_read_mux: assert property (
		bus.rd && bus.addr == `ADDR_DATA |=>
		rd_data == $past(read_v[7:0]))
		else $error("port read value wrong");
	a_port_c_width: assert property (
		bus.rd && bus.addr == `ADDR_DATA + 8'h02 |=>
		rd_data[7:3] == 5'h00)
		else $error("port C wider than three bits");
	a_port_f_width: assert property (
		bus.rd && bus.addr == `ADDR_DATA + 8'h05 |=>
		rd_data[7:4] == 4'h0)
		else $error("port F wider than four bits");
	a_async_clock: assert property (
		alt_r[`ALT_SER_EN] && alt_r[`ALT_ASYNC] |=> !pins.oe[`PIN_C0])
		else $error("clock pin driven in async mode");
	a_serial_out: assert property (
		alt_r[`ALT_SER_EN] |=> pins.o[`PIN_C1] == $past(periph.ser_data))
		else $error("serial data not on pin");
	a_timer8_out: assert property (
		alt_r[`ALT_TMR8_OUT] |=> pins.o[`PIN_F0] == $past(periph.tmr8))
		else $error("timer8 output not on pin");
	a_timer16_out: assert property (
		alt_r[`ALT_TMR16_OUT] |=> pins.o[`PIN_F1] == $past(periph.tmr16))
		else $error("timer16 output not on pin");
	a_ext_rise: assert property (
		edge_r[1:0] == 2'b01 && sync2_r[`PIN_D0] && !hist_r[`PIN_D0]
		|=> status_r[0] && (irq || !mask_r[0]))
		else $error("rising edge not flagged");
	a_ext_fall_only: assert property (
		edge_r[1:0] == 2'b10 && sync2_r[`PIN_D0] && !hist_r[`PIN_D0]
		&& !status_r[0] |=> !status_r[0])
		else $error("status set without valid edge");
	a_read_idle: assert property (
		!bus.rd |=> rd_data == 8'h00)
		else $error("read data not cleared");
	a_dir_d_narrow: assert property (
		bus.wr && bus.addr == `ADDR_DIR + 8'h03 |=>
		dir_r[3][7:3] == 5'h00)
		else $error("port D direction wider than three bits");
	a_dir_f_narrow: assert property (
		bus.wr && bus.addr == `ADDR_DIR + 8'h05 |=>
		dir_r[5][7:4] == 4'h0)
		else $error("port F direction wider than four bits");
	a_port_b_full: assert property (
		bus.wr && bus.addr == `ADDR_DATA + 8'h01 |=>
		latch_r[1] == $past(bus.wdata))
		else $error("port B latch not eight bits");
	a_master_clock: assert property (
		alt_r[`ALT_SER_EN] && !alt_r[`ALT_ASYNC] &&
		alt_r[`ALT_SCK_MST] |=>
		pins.o[`PIN_C0] == $past(periph.ser_clk))
		else $error("serial clock not on pin");
	a_slave_clock: assert property (
		alt_r[`ALT_SER_EN] && !alt_r[`ALT_SCK_MST] |=> !pins.oe[`PIN_C0])
		else $error("clock pin driven as slave");
	a_alt_input_only: assert property (
		!dir_v[`PIN_F1] |=> !pins.oe[`PIN_F1])
		else $error("alternate output drives an input pin");
	a_reset_config: assert property (
		$rose(rst_n) |-> alt_r == `RST_ALT && edge_r == `RST_EDGE)
		else $error("alternates active after reset");

	// ======================================================
	// Checks on synchronised inputs and events
	// The chain resets to zero, so compare only after two live edges
	a_sync_serial_in: assert property (
		$past(rst_n, 2) && $past(rst_n) |->
		to_periph.sync_serial_in == $past(pin_in[`PIN_C2], 2))
		else $error("serial data input not synchronised");
	a_async_clock_in: assert property (
		$past(rst_n, 2) && $past(rst_n) |->
		to_periph.async_serial_clock_in == $past(pin_in[`PIN_C0], 2))
		else $error("async clock input not synchronised");
	a_timer8_in: assert property (
		$past(rst_n, 2) && $past(rst_n) |->
		to_periph.timer8_count_in == $past(pin_in[`PIN_F0], 2))
		else $error("timer8 count input not synchronised");
	a_capture_in: assert property (
		$past(rst_n, 2) && $past(rst_n) |->
		to_periph.capture_trigger_in == $past(pin_in[`PIN_D0 + 2], 2))
		else $error("capture input not synchronised");
	a_key_inputs: assert property (
		$past(rst_n, 2) && $past(rst_n) |->
		to_periph.key_return_inputs == $past(pin_in[29:22], 2))
		else $error("key return inputs not synchronised");
	a_ext_irq_in: assert property (
		$past(rst_n, 2) && $past(rst_n) |->
		to_periph.ext_irq == $past(pin_in[21:19], 2))
		else $error("interrupt inputs not synchronised");
	a_ext_fall: assert property (
		edge_r[3] && !sync2_r[`PIN_D0 + 1] && hist_r[`PIN_D0 + 1]
		|=> status_r[1])
		else $error("falling edge on irq b not flagged");
	a_key_fall: assert property (
		hist_r[`PIN_E0] && !sync2_r[`PIN_E0] && !dir_v[`PIN_E0]
		|=> status_r[`ST_KEY])
		else $error("key return edge not flagged");
	a_status_clear: assert property (
		bus.wr && bus.addr == `ADDR_STAT && bus.wdata[0] && !events[0]
		|=> !status_r[0])
		else $error("status bit not cleared by write");

endmodule : port_pins_with_alternates

//--- tb/port_board.sv
// Board-side pin model: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module port_board
	import port_pkg::*;
(
	input wire logic clock,
	input wire pin_drive_s pins,
	input wire logic [33:0] ext_val,
	input wire logic [33:0] ext_en,
	output logic [33:0] pin_in
);
	logic [33:0] float_r = 34'h0;

	// ==========================================================
	// Floating lines
	// Undriven lines wander, so a missing pull-up never reads as a quiet 1
	always @(posedge clock)
	begin
		float_r <= ~float_r;
	end

	// ==========================================================
	// Wire resolution
	always_comb
	begin
		for (int i = 0; i < 34; i++)
		begin
			if (pins.oe[i])
				pin_in[i] = pins.o[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pins.pu[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = float_r[i];
		end
	end
endmodule : port_board

//--- tb/port_pins_with_alternates_bench.sv
// Self-checking bench for the six-port pin block
`timescale 1ns/1ps
`include "port_pins_cfg.svh"
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			miscompares++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module port_pins_with_alternates_bench
	import port_pkg::*;
;
	localparam logic [7:0] port_mask [6] = '{8'hff, 8'hff, 8'h07, 8'h07,
		8'hff, 8'h0f};
	localparam int port_lsb [6] = '{0, 8, 16, 19, 22, 30};
	logic clock;
	logic rst_n;
	reg_req_s bus;
	logic [7:0] rd_data;
	logic [33:0] pin_in;
	pin_drive_s pins;
	periph_drive_s periph;
	alt_in_s to_periph;
	logic irq;
	logic [33:0] ext_val;
	logic [33:0] ext_en;
	int miscompares;
	int tests_run;
	logic [7:0] sl;

	port_pins_with_alternates u_dut (.clock(clock), .rst_n(rst_n),
		.bus(bus), .rd_data(rd_data), .pin_in(pin_in), .pins(pins),
		.periph(periph), .to_periph(to_periph), .irq(irq));
	port_board u_board (.clock(clock), .pins(pins), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	// ==========================================================
	// Bus tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		`CHK(rd_data, e)
	endtask : chk_rd

	task automatic settle;
		repeat (4) @(posedge clock);
	endtask : settle

	task automatic end_sim;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// ==========================================================
	// Clock and watchdog
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		end_sim();
	end

	// ==========================================================
	// Scenarios
	initial
	begin
		miscompares = 0;
		tests_run = 0;
		rst_n = 1'b0;
		bus = '0;
		periph = '0;
		ext_val = 34'h2_aaaa_aaaa;
		ext_en = '1;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		`CHK(pins.oe, 34'h0)
		`CHK(pins.pu, 34'h0)
		`CHK(irq, 1'b0)
		for (int p = 0; p < 6; p++)
		begin
			chk_rd(8'(`ADDR_DIR + p), 8'h00);
			chk_rd(8'(`ADDR_PU + p), 8'h00);
		end
		chk_rd(`ADDR_ALT, 8'h00);
		chk_rd(`ADDR_EDGE, 8'h00);
		chk_rd(`ADDR_STAT, 8'h00);
		wr(8'h30, 8'hff);
		chk_rd(8'h30, 8'h00);
		chk_rd(8'h06, 8'h00);
		// Mixed directions in every port, narrow ports clipped to width
		for (int p = 0; p < 6; p++)
		begin
			wr(8'(`ADDR_DIR + p), 8'ha5);
			wr(8'(`ADDR_DATA + p), 8'h3c);
			settle();
			sl = 8'(pins.oe >> port_lsb[p]) & port_mask[p];
			`CHK(sl, 8'ha5 & port_mask[p])
			chk_rd(8'(`ADDR_DIR + p), 8'ha5 & port_mask[p]);
			sl = 8'(ext_val >> port_lsb[p]);
			chk_rd(8'(`ADDR_DATA + p), ((8'h24) | (sl & 8'h5a))
				& port_mask[p]);
			wr(8'(`ADDR_DIR + p), 8'h00);
		end
		// Pull-up acts only on the input half of port A
		wr(8'(`ADDR_PU), 8'hff);
		wr(8'(`ADDR_DIR), 8'h0f);
		ext_en <= ~34'hf0;
		settle();
		`CHK(pins.pu[7:0], 8'hf0)
		chk_rd(`ADDR_DATA, 8'hfc);
		ext_en <= '1;
		wr(8'(`ADDR_PU), 8'h00);
		wr(8'(`ADDR_DIR), 8'h00);
		// Input alternates see synchronised pin levels
		ext_val <= 34'h1_5555_5555;
		settle();
		`CHK(to_periph.timer8_count_in, 1'b1)
		`CHK(to_periph.sync_serial_in, 1'b1)
		`CHK(to_periph.sync_serial_clock, 1'b1)
		`CHK(to_periph.key_return_inputs, 8'h55)
		// Alternate outputs on C1, F0, F1
		wr(`ADDR_ALT, 8'h19);
		wr(8'(`ADDR_DIR + 2), 8'h02);
		wr(8'(`ADDR_DIR + 5), 8'h03);
		periph <= 4'b0110;
		settle();
		`CHK(pins.o[17], 1'b1)
		`CHK(pins.o[30], 1'b1)
		`CHK(pins.o[31], 1'b0)
		periph <= 4'b1001;
		settle();
		`CHK(pins.o[17], 1'b0)
		`CHK(pins.o[30], 1'b0)
		`CHK({pins.oe[31], pins.o[31]}, 2'b11)
		// Serial clock: driven as master, input only in async mode
		wr(`ADDR_ALT, 8'h05);
		wr(8'(`ADDR_DIR + 2), 8'h01);
		settle();
		`CHK({pins.oe[16], pins.o[16]}, 2'b11)
		wr(`ADDR_ALT, 8'h07);
		// Outside level differs from the driven one, so a driven pin shows
		ext_val <= 34'h1_5554_5555;
		settle();
		`CHK(pins.oe[16], 1'b0)
		`CHK(to_periph.async_serial_clock_in, 1'b0)
		wr(`ADDR_ALT, 8'h00);
		wr(8'(`ADDR_DIR + 2), 8'h00);
		wr(8'(`ADDR_DIR + 5), 8'h00);
		// Edge modes on all three interrupt pins, key falling edge
		wr(`ADDR_MASK, 8'h0f);
		for (int m = 0; m < 4; m++)
		begin
			ext_val <= 34'h0_0040_0000;
			settle();
			wr(`ADDR_EDGE, 8'(m * 8'h15));
			wr(`ADDR_STAT, 8'h0f);
			ext_val <= 34'h0_0078_0000;
			settle();
			`CHK(to_periph.capture_trigger_in, 1'b1)
			`CHK(to_periph.ext_irq, 3'h7)
			`CHK(irq, 1'(m & 1))
			chk_rd(`ADDR_STAT, (m & 1) ? 8'h07 : 8'h00);
			wr(`ADDR_STAT, 8'h0f);
			ext_val <= 34'h0;
			settle();
			chk_rd(`ADDR_STAT, ((m & 2) ? 8'h07 : 8'h00) | 8'h08);
		end
		wr(`ADDR_MASK, 8'h00);
		settle();
		`CHK(irq, 1'b0)
		wr(`ADDR_STAT, 8'h01);
		chk_rd(`ADDR_STAT, 8'h0e);
		end_sim();
	end
endmodule : port_pins_with_alternates_bench
